// ### design/twe_pkg.sv
// package for the two-wire eeprom slave port: sizes, timing, field positions, state codes
// assumes a single 200 MHz system clock that oversamples the bus pins
package twe_pkg;

   // ----------------------------------------------------------------
   // storage geometry
   // ----------------------------------------------------------------
   localparam int ARRAY_AW    = 17;
   localparam int ARRAY_DEPTH = 131072;
   localparam int PAGE_AW     = 8;
   localparam int PAGE_BYTES  = 256;
   localparam int BYTE_W      = 8;
   localparam int CNT_W       = 9;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 200;
   localparam int WRITE_TIME_US = 5000;
   // longest time; the product is a whole number of cycles, so nothing is rounded
   localparam int WRITE_CYCLES  = (WRITE_TIME_US * CLK_MHZ);
   localparam int TMR_W         = 21;

   // ----------------------------------------------------------------
   // device select byte layout
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam int DEV_RW_BIT   = 0;
   localparam int DEV_A16_BIT  = 1;
   localparam int DEV_LO_BIT   = 2;
   localparam int DEV_HI_BIT   = 3;
   localparam int DEV_TYPE_LSB = 4;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK0 = 4'h8;
   localparam logic [3:0] BIT_ACK1 = 4'h9;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_RX    = 7'h02,
      S_ACK   = 7'h04,
      S_TX    = 7'h08,
      S_TXACK = 7'h10,
      S_WAIT  = 7'h20,
      S_PROG  = 7'h40
   } twe_state_t;

   typedef enum logic [1:0] {
      K_DEV = 2'h0,
      K_AHI = 2'h1,
      K_ALO = 2'h2,
      K_DAT = 2'h3
   } twe_kind_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic a_lo;
      logic a_hi;
      logic wp;
   } twe_pins_t;

   // idle bus: clock and data high, so no false edge follows reset
   localparam twe_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, a_lo: 1'b0, a_hi: 1'b0, wp: 1'b0};

endpackage : twe_pkg

// ### design/twe_mem.sv
// single-port byte memory with registered read data
// assumes one write or one read address per cycle; no reset on contents
`timescale 1ns/1ps
module twe_mem #(
   parameter int AW = 17,
   parameter int DW = 8
) (
   input  wire logic          i_clk_sys,
   input  wire logic          i_resetn,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   output logic      [DW-1:0] o_rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= mem[i_addr];
      end
   end

endmodule : twe_mem

// ### design/twe_port.sv
// two-wire eeprom slave port: pin-level front end, page buffer, self-timed programming
// assumes the bus pins are asynchronous to i_clk_sys and resolved outside (open drain, pull-ups)
//
// How it works
// - data bits are taken from the data line at each clock rising edge.
// - read data changes the driven level only after a clock falling edge.
// - data line is only pulled low or released, never driven high.
// - a transaction is answered only if its address bits equal the straps.
// - four strap combinations let four such ports share one bus.
// - undriven strap and protect inputs count as low.
// - protect input high blocks every array write; low lets writes through.
// - one byte up to a full 256-byte page per write transaction.
// - internal programming finishes within 5 ms without bus clocking.
// - storage is 131072 bytes, addressed byte by byte.
// - single reads at a chosen address and sequential reads are supported.
// - works at 100 kHz, 400 kHz and 1 MHz clock rates.
`timescale 1ns/1ps
module twe_port #(
   parameter int WRITE_CYCLES = twe_pkg::WRITE_CYCLES
) (
   input  wire logic i_clk_sys,
   input  wire logic i_resetn,
   input  wire logic i_scl,
   input  wire logic i_sda,
   input  wire logic i_addr_strap_low_bit,
   input  wire logic i_addr_strap_high_bit,
   input  wire logic i_write_protect,
   output logic      o_sda_out,
   output logic      o_sda_oe,
   output logic      o_write_busy
);

   // ----------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------
   typedef struct packed {
      twe_pkg::twe_pins_t                  meta;
      twe_pkg::twe_pins_t                  sync;
      logic [1:0]                          prev;
      twe_pkg::twe_state_t                 st;
      twe_pkg::twe_kind_t                  kind;
      logic [3:0]                          bit_cnt;
      logic [twe_pkg::BYTE_W-1:0]          shreg;
      logic                                rd;
      logic                                host_ack;
      logic [twe_pkg::ARRAY_AW-1:0]        addr;
      logic [twe_pkg::ARRAY_AW-1:0]        wbase;
      logic [twe_pkg::CNT_W-1:0]           wcnt;
      logic [twe_pkg::TMR_W-1:0]           timer;
      logic                                sda_oe;
      logic                                sda_lvl;
      logic                                busy;
   } twe_regs_t;

   twe_regs_t                       r;
   twe_regs_t                       next_r;
   twe_pkg::twe_pins_t              pins;
   logic                            scl_r;
   logic                            scl_f;
   logic                            start;
   logic                            stop;
   logic                            do_load;
   logic                            arr_we;
   logic                            pbuf_we;
   logic                            oe_cause;
   logic [twe_pkg::BYTE_W-1:0]      new_byte;
   logic [twe_pkg::PAGE_AW-1:0]     copy_off;
   logic [twe_pkg::CNT_W-1:0]       copy_i;
   logic [twe_pkg::ARRAY_AW-1:0]    arr_addr;
   logic [twe_pkg::PAGE_AW-1:0]     pbuf_addr;
   logic [twe_pkg::BYTE_W-1:0]      arr_rdata;
   logic [twe_pkg::BYTE_W-1:0]      pbuf_rdata;

   localparam logic [twe_pkg::TMR_W-1:0] TMR_LAST = twe_pkg::TMR_W'(WRITE_CYCLES - 1);
   localparam logic [twe_pkg::CNT_W-1:0] CNT_FULL = twe_pkg::CNT_W'(twe_pkg::PAGE_BYTES);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic dev_hit(input logic [7:0] b, input logic hi, input logic lo);
      dev_hit = (b[7:twe_pkg::DEV_TYPE_LSB] == twe_pkg::DEV_TYPE_CODE)
             && (b[twe_pkg::DEV_HI_BIT] == hi)
             && (b[twe_pkg::DEV_LO_BIT] == lo);
   endfunction : dev_hit

   // straps and protect arrive already resolved; a floating pin is pulled low outside
   assign pins = '{scl: i_scl, sda: i_sda, a_lo: i_addr_strap_low_bit,
                   a_hi: i_addr_strap_high_bit, wp: i_write_protect};

   // ----------------------------------------------------------------
   // bus events
   // ----------------------------------------------------------------
   // 5 ns sampling leaves well over 50 samples per half period even at 1 MHz
   assign scl_r    = r.sync.scl & ~r.prev[1];
   assign scl_f    = ~r.sync.scl & r.prev[1];
   // idle clock high lets data edges mark frame boundaries
   assign start    = r.sync.scl & r.prev[1] & ~r.sync.sda & r.prev[0];
   assign stop     = r.sync.scl & r.prev[1] & r.sync.sda & ~r.prev[0];
   assign oe_cause = scl_f | start | stop;
   assign new_byte = {r.shreg[6:0], r.sync.sda};

   // ----------------------------------------------------------------
   // page copy addressing
   // ----------------------------------------------------------------
   // even cycle presents the buffer address, odd cycle writes the array
   assign copy_i    = r.timer[twe_pkg::CNT_W:1];
   assign copy_off  = twe_pkg::PAGE_AW'(r.wbase[twe_pkg::PAGE_AW-1:0] + r.timer[twe_pkg::PAGE_AW:1]);
   assign pbuf_addr = (r.st == twe_pkg::S_PROG) ? copy_off : r.addr[twe_pkg::PAGE_AW-1:0];
   assign arr_addr  = (r.st == twe_pkg::S_PROG)
                    ? {r.wbase[twe_pkg::ARRAY_AW-1:twe_pkg::PAGE_AW], copy_off} : r.addr;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r  = r;
      do_load = 1'b0;
      arr_we  = 1'b0;
      pbuf_we = 1'b0;
      // first stage feeds only the second stage
      next_r.meta = pins;
      next_r.sync = r.meta;
      next_r.prev = {r.sync.scl, r.sync.sda};
      unique case (r.st)
         twe_pkg::S_IDLE, twe_pkg::S_WAIT: begin
         end
         twe_pkg::S_RX: begin
            if (scl_r) begin
               next_r.shreg   = new_byte;
               next_r.bit_cnt = r.bit_cnt + 4'h1;
               if (r.bit_cnt == twe_pkg::BIT_LAST) begin
                  next_r.st = twe_pkg::S_ACK;
                  unique case (r.kind)
                     twe_pkg::K_DEV: begin
                        if (dev_hit(new_byte, r.sync.a_hi, r.sync.a_lo)) begin
                           next_r.rd = new_byte[twe_pkg::DEV_RW_BIT];
                           if (!new_byte[twe_pkg::DEV_RW_BIT]) begin
                              next_r.kind = twe_pkg::K_AHI;
                              next_r.addr[twe_pkg::ARRAY_AW-1] = new_byte[twe_pkg::DEV_A16_BIT];
                           end
                        end else begin
                           next_r.st = twe_pkg::S_WAIT;
                        end
                     end
                     twe_pkg::K_AHI: begin
                        next_r.addr[15:8] = new_byte;
                        next_r.kind       = twe_pkg::K_ALO;
                     end
                     twe_pkg::K_ALO: begin
                        next_r.addr[7:0] = new_byte;
                        next_r.wbase     = {r.addr[twe_pkg::ARRAY_AW-1:twe_pkg::PAGE_AW], new_byte};
                        next_r.wcnt      = '0;
                        next_r.kind      = twe_pkg::K_DAT;
                     end
                     twe_pkg::K_DAT: begin
                        // address rolls within the page; extra bytes overwrite the oldest
                        pbuf_we          = 1'b1;
                        next_r.addr[7:0] = r.addr[7:0] + 8'h01;
                        if (r.wcnt != CNT_FULL) begin
                           next_r.wcnt = r.wcnt + 9'h001;
                        end
                     end
                  endcase
               end
            end
         end
         twe_pkg::S_ACK: begin
            if (scl_f) begin
               if (r.bit_cnt == twe_pkg::BIT_ACK0) begin
                  next_r.sda_oe  = 1'b1;
                  next_r.bit_cnt = twe_pkg::BIT_ACK1;
               end else if (r.rd) begin
                  do_load = 1'b1;
               end else begin
                  next_r.sda_oe  = 1'b0;
                  next_r.bit_cnt = 4'h0;
                  next_r.st      = twe_pkg::S_RX;
               end
            end
         end
         twe_pkg::S_TX: begin
            if (scl_f) begin
               if (r.bit_cnt == twe_pkg::BIT_ACK0) begin
                  next_r.sda_oe = 1'b0;
                  next_r.st     = twe_pkg::S_TXACK;
               end else begin
                  next_r.sda_oe  = ~r.shreg[7];
                  next_r.shreg   = {r.shreg[6:0], 1'b0};
                  next_r.bit_cnt = r.bit_cnt + 4'h1;
               end
            end
         end
         twe_pkg::S_TXACK: begin
            if (scl_r) begin
               next_r.host_ack = ~r.sync.sda;
            end
            if (scl_f) begin
               if (r.host_ack) begin
                  do_load = 1'b1;
               end else begin
                  next_r.st = twe_pkg::S_WAIT;
               end
            end
         end
         twe_pkg::S_PROG: begin
            if (r.timer[0] && (copy_i < r.wcnt)) begin
               arr_we = 1'b1;
            end
            if (r.timer == TMR_LAST) begin
               next_r.st = twe_pkg::S_IDLE;
            end else begin
               next_r.timer = r.timer + 21'h000001;
            end
         end
         default: begin
            next_r.st = twe_pkg::S_IDLE;
         end
      endcase
      // read data is prefetched: arr_addr follows r.addr long before the load edge
      if (do_load) begin
         next_r.sda_oe   = ~arr_rdata[7];
         next_r.shreg    = {arr_rdata[6:0], 1'b0};
         next_r.bit_cnt  = 4'h1;
         next_r.host_ack = 1'b0;
         next_r.addr     = r.addr + 17'h00001;
         next_r.st       = twe_pkg::S_TX;
      end
      // frame edges are not seen while programming
      if (r.st != twe_pkg::S_PROG) begin
         if (start) begin
            next_r.st      = twe_pkg::S_RX;
            next_r.kind    = twe_pkg::K_DEV;
            next_r.bit_cnt = 4'h0;
            next_r.rd      = 1'b0;
            next_r.sda_oe  = 1'b0;
         end else if (stop) begin
            next_r.sda_oe = 1'b0;
            next_r.kind   = twe_pkg::K_DEV;
            next_r.timer  = '0;
            if (r.kind == twe_pkg::K_DAT && r.wcnt != '0 && !r.sync.wp) begin
               next_r.st = twe_pkg::S_PROG;
            end else begin
               next_r.st = twe_pkg::S_IDLE;
            end
         end
      end
      next_r.sda_lvl = 1'b0;
      next_r.busy    = (next_r.st == twe_pkg::S_PROG);
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         r <= '{meta: twe_pkg::PINS_IDLE, sync: twe_pkg::PINS_IDLE, prev: 2'h3, st: twe_pkg::S_IDLE,
                kind: twe_pkg::K_DEV, bit_cnt: 4'h0, shreg: 8'h00, rd: 1'b0, host_ack: 1'b0, addr: 17'h00000,
                wbase: 17'h00000, wcnt: 9'h000, timer: 21'h000000, sda_oe: 1'b0,
                sda_lvl: 1'b0, busy: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign o_sda_out    = r.sda_lvl;
   assign o_sda_oe     = r.sda_oe;
   assign o_write_busy = r.busy;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   twe_mem #(.AW(twe_pkg::ARRAY_AW), .DW(twe_pkg::BYTE_W)) u_array (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_we      (arr_we),
      .i_addr    (arr_addr),
      .i_wdata   (pbuf_rdata),
      .o_rdata   (arr_rdata)
   );

   // page buffer lets the bus run at full rate while the array is written later
   twe_mem #(.AW(twe_pkg::PAGE_AW), .DW(twe_pkg::BYTE_W)) u_page (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_we      (pbuf_we),
      .i_addr    (pbuf_addr),
      .i_wdata   (new_byte),
      .o_rdata   (pbuf_rdata)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   sequence s_load;
      do_load;
   endsequence

   sequence s_prog_entry;
      r.st == twe_pkg::S_PROG && r.timer == '0;
   endsequence

   sequence s_bad_strap;
      r.st == twe_pkg::S_RX && r.kind == twe_pkg::K_DEV && scl_r && !stop && r.bit_cnt == twe_pkg::BIT_LAST
      && (r.shreg[2] != r.sync.a_hi || r.shreg[1] != r.sync.a_lo);
   endsequence

   rise_capture_a: assert property (r.st == twe_pkg::S_RX && scl_r && !stop
      |=> r.shreg[0] == $past(r.sync.sda))
      else $error("data bit not captured on clock rise");

   oe_after_fall_a: assert property ($changed(o_sda_oe) |-> $past(oe_cause))
      else $error("data drive changed without a clock fall");

   drain_only_a: assert property (o_sda_oe |-> o_sda_out == 1'b0)
      else $error("data line driven high");

   strap_mismatch_a: assert property (s_bad_strap |=> r.st == twe_pkg::S_WAIT ##1 !o_sda_oe)
      else $error("answered a foreign address");

   protect_blocks_a: assert property (stop && r.st != twe_pkg::S_PROG && r.sync.wp
      |=> r.st != twe_pkg::S_PROG)
      else $error("write started while protected");

   page_wrap_a: assert property (pbuf_we |=> r.addr[16:8] == $past(r.addr[16:8])
      && r.wcnt <= CNT_FULL)
      else $error("page write left its page");

   prog_bound_a: assert property (r.st == twe_pkg::S_PROG |-> r.timer <= TMR_LAST)
      else $error("programming overran its time");

   prog_end_a: assert property (r.st == twe_pkg::S_PROG && r.timer == TMR_LAST
      |=> r.st == twe_pkg::S_IDLE && !o_write_busy)
      else $error("programming did not end on time");

   seq_step_a: assert property (s_load |=> r.addr == $past(r.addr) + 17'h00001
      && r.sda_oe == ~$past(arr_rdata[7]))
      else $error("sequential read did not step");

   busy_deaf_a: assert property (s_prog_entry |=> (r.st == twe_pkg::S_PROG && !o_sda_oe)[*8])
      else $error("bus answered during programming");

endmodule : twe_port

// ### bench/twe_host_model.sv
// bus host model: drives the serial clock and pulls the data line low, open drain
// assumes the bench resolves the data wire with a pull-up from both parties' pull-down enables
`timescale 1ns/1ps
module twe_host_model (
   input  wire logic i_clk_sys,
   input  wire logic i_sda_wire,
   output logic      o_scl,
   output logic      o_sda_low
);
   // ----------------------------------------------------------------
   // bus timing: 16 system clocks per bit, an 80 ns bus clock
   // ----------------------------------------------------------------
   initial begin
      o_scl     = 1'b1; // idle level
      o_sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick

   // one bit each way; a 1 leaves the line to the device
   task automatic xfer_bit(input logic b, output logic r);
      o_sda_low <= ~b;
      tick(4);
      o_scl <= 1'b1;
      tick(4);
      r = i_sda_wire;
      tick(4);
      o_scl <= 1'b0;
      tick(4);
   endtask : xfer_bit

   // also serves as a repeated start from a low clock
   task automatic start_cond;
      o_sda_low <= 1'b0;
      tick(4);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b1;
      tick(8);
      o_scl <= 1'b0;
      tick(4);
   endtask : start_cond

   // leaves the clock high afterwards, as an idle bus needs
   task automatic stop_cond;
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b1;
      tick(4);
      o_sda_low <= 1'b0;
      tick(8);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask : send_byte

   task automatic recv_byte(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, r);
         b[i] = r;
      end
      xfer_bit(nack, r);
   endtask : recv_byte
endmodule : twe_host_model

// ### bench/tb_top.sv
// self-checking bench for the two-wire eeprom slave port with a host model on the bus
// assumes a short programming time so each write cycle lasts 600 system clocks
`timescale 1ns/1ps
module tb_top;
   localparam int WC     = 600;
   localparam int CLK_NS = 5;
   logic i_clk_sys, i_resetn, i_addr_strap_low_bit, i_addr_strap_high_bit, i_write_protect;
   logic scl, sda_low, sda_wire, o_sda_out, o_sda_oe, o_write_busy;
   int   miscompares = 0;
   int   cmp_count   = 0;

   // pull-up wins unless a party pulls low
   assign sda_wire = (sda_low | (o_sda_oe & ~o_sda_out)) ? 1'b0 : 1'b1;

   twe_port #(.WRITE_CYCLES(WC)) u_dut (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_wire),
      .i_addr_strap_low_bit(i_addr_strap_low_bit), .i_addr_strap_high_bit(i_addr_strap_high_bit),
      .i_write_protect(i_write_protect), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
      .o_write_busy(o_write_busy));
   twe_host_model u_host (.i_clk_sys(i_clk_sys), .i_sda_wire(sda_wire), .o_scl(scl), .o_sda_low(sda_low));

   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   // ----------------------------------------------------------------
   // compare and closing
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   function automatic logic [7:0] dat(input int k);
      return 8'h5A + 8'(k) * 8'h3B;
   endfunction : dat

   always @(negedge i_clk_sys) if (o_sda_oe === 1'b1) chk({31'h0, o_sda_out}, 32'h0, "drive level");

   // ----------------------------------------------------------------
   // transaction helpers
   // ----------------------------------------------------------------
   task automatic hdr(input logic [1:0] sel, input logic [16:0] a, input logic ack_exp);
      logic ack;
      u_host.start_cond();
      u_host.send_byte({twe_pkg::DEV_TYPE_CODE, sel, a[16], 1'b0}, ack);
      chk({31'h0, ack}, {31'h0, ack_exp}, "select ack");
      if (ack) begin
         u_host.send_byte(a[15:8], ack);
         chk({31'h0, ack}, 32'h1, "address high ack");
         u_host.send_byte(a[7:0], ack);
         chk({31'h0, ack}, 32'h1, "address low ack");
      end
   endtask : hdr

   task automatic wr(input logic [16:0] a, input int n, input int k);
      logic ack;
      hdr(2'h2, a, 1'b1);
      for (int i = 0; i < n; i++) begin
         u_host.send_byte(dat(k + i), ack);
         chk({31'h0, ack}, 32'h1, "data ack");
      end
      u_host.stop_cond();
   endtask : wr

   task automatic rd(input logic [16:0] a, input int n, input int k);
      logic ack;
      logic [7:0] b;
      hdr(2'h2, a, 1'b1);
      u_host.start_cond();
      u_host.send_byte({twe_pkg::DEV_TYPE_CODE, 2'h2, 1'b0, 1'b1}, ack);
      chk({31'h0, ack}, 32'h1, "read select ack");
      for (int i = 0; i < n; i++) begin
         u_host.recv_byte(i == n - 1, b);
         chk({24'h0, b}, {24'h0, dat(k + i)}, "read byte");
      end
      u_host.stop_cond();
   endtask : rd

   // ignored polling while busy, then a bounded programming time
   task automatic wait_prog(input logic busy_exp);
      logic ack;
      int n;
      int len;
      time t0;
      n = 0;
      len = 0;
      while (o_write_busy !== 1'b1 && n < 20) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk({31'h0, o_write_busy}, {31'h0, busy_exp}, "busy after stop");
      t0 = $time;
      if (busy_exp) begin
         u_host.start_cond();
         u_host.send_byte({twe_pkg::DEV_TYPE_CODE, 2'h2, 1'b0, 1'b0}, ack);
         chk({31'h0, ack}, 32'h0, "ack while busy");
         u_host.stop_cond();
      end
      while (o_write_busy === 1'b1 && len <= WC) begin
         @(posedge i_clk_sys);
         len++;
      end
      // whole busy span, polling included, must fit the programming budget
      chk({31'h0, ($time - t0) <= WC * CLK_NS}, 32'h1, "program time");
   endtask : wait_prog

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // every strap setting answers only its own select code
   task automatic straps_test;
      for (int s = 0; s < 4; s++) begin
         {i_addr_strap_high_bit, i_addr_strap_low_bit} <= 2'(s);
         for (int sel = 0; sel < 4; sel++) begin
            hdr(2'(sel), 17'h00000, sel == s);
            u_host.stop_cond();
            wait_prog(1'b0);
         end
      end
      {i_addr_strap_high_bit, i_addr_strap_low_bit} <= 2'h2;
   endtask : straps_test

   // page wrap at the top of a page, and the upper address bit kept apart
   task automatic page_test;
      wr(17'h120FE, 3, 0);
      wait_prog(1'b1);
      wr(17'h020FE, 1, 7);
      wait_prog(1'b1);
      rd(17'h120FE, 2, 0);
      rd(17'h12000, 1, 2);
      rd(17'h020FE, 1, 7);
   endtask : page_test

   task automatic protect_test;
      i_write_protect <= 1'b1;
      wr(17'h120FE, 1, 9);
      wait_prog(1'b0);
      i_write_protect <= 1'b0;
      rd(17'h120FE, 1, 0);
   endtask : protect_test

   initial begin
      i_resetn              = 1'b0;
      i_addr_strap_low_bit  = 1'b0;
      i_addr_strap_high_bit = 1'b0;
      i_write_protect       = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      repeat (6) @(posedge i_clk_sys);
      straps_test();
      page_test();
      protect_test();
      summarize();
   end

   initial begin
      repeat (90000) @(posedge i_clk_sys);
      miscompares++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
   end
endmodule : tb_top
